// *** verilog/twi_top.v ***
// Two-wire interface: software-driven master, hardware slave, shared pins
//
// Overview of operation
// - Two-wire and SPI logic share the two pins; only one drives them.
// - Two-wire owns the pins when the SPI enable bit is clear.
// - Control bit 3 set selects software master, clear selects hardware slave.
// - Master mode drives data-out bit 7 onto data pin while drive enable set.
// - Master mode bit 6 makes data pin output when set, input when clear.
// - Master mode drives clock-out bit 5 onto the clock pin.
// - Master mode with drive enable clear latches data pin into bit 4 on clock.
// - In slave mode, control bit 2 set holds slave logic in reset.
// - Slave sets direction bit 1 while transmitting, clears it while receiving.
// - Slave sets flag bit 0 after each byte transmitted or received.
// - A data register access clears the byte-done flag unless a new byte-done event lands in the same cycle.
// - Data writes supply next transmit byte; reads return oldest unread received byte.
// - Seven-bit own address lives in a writable register resetting to 55H.
`timescale 1ns/10ps
`include "twi_regs.vh"
module twi_top #(
    parameter BUF_DEPTH = 2,
    parameter BUF_AW = 1
) (
    input wire SYS_CLK, // Core clock, 250 MHz
    input wire RSTN, // Synchronous reset, active low
    input wire CE, // Clock enable, freezes all state while low
    input wire [7:0] SFR_ADDR, // Register address
    input wire SFR_WR, // Register write strobe
    input wire SFR_RD, // Register read strobe
    input wire [7:0] SFR_WDATA, // Write data
    output reg [7:0] SFR_RDATA, // Read data, valid cycle after strobe
    input wire SERIAL_PERIPHERAL_ENABLE, // SPI enable bit from SPI control
    input wire SPI_DATA_OUT, // SPI block data pin drive value
    input wire SPI_DATA_OE, // SPI block data pin enable
    input wire SPI_CLOCK_OUT, // SPI block clock pin drive value
    input wire SPI_CLOCK_OE, // SPI block clock pin enable
    input wire SERIAL_DATA_PIN_IN, // Data pin level
    output reg SERIAL_DATA_PIN_OUT, // Data pin drive value
    output reg SERIAL_DATA_PIN_OE, // Data pin driven when high
    input wire SERIAL_CLOCK_PIN_IN, // Clock pin level
    output reg SERIAL_CLOCK_PIN_OUT, // Clock pin drive value
    output reg SERIAL_CLOCK_PIN_OE, // Clock pin driven when high
    output reg BYTE_DONE_IRQ // Byte-done flag towards the interrupt system
);
    // Slave states
    localparam [2:0] ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ACK = 3'h2, ST_RX = 3'h3;
    localparam [2:0] ST_TX = 3'h4, ST_TXACK = 3'h5, ST_HOLD = 3'h6;

    // Software-visible state and the shift register
    reg mdo_reg, mde_reg, mco_reg, mdi_reg, msel_reg, srst_reg, dir_reg, done_reg;
    reg [7:0] own_addr_reg, rx_data_reg, tx_data_reg, sh_reg;

    // Slave engine state
    reg [2:0] state_reg;
    reg [3:0] cnt_reg;
    reg sda_low_reg, scl_low_reg, scl_d_reg, sda_d_reg;

    wire [1:0] pins_sync;
    wire scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, twi_on, slave_run, tx_byte_done;
    wire acc_data, wr_ctrl, buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    wire [7:0] buf_out_data;
    reg buf_push;

    // Pin levels come from outside the clock domain
    twi_sync #(
        .WIDTH(2),
        .INIT(2'h3)
    ) u_sync (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .ce(CE),
        .d_in({SERIAL_CLOCK_PIN_IN, SERIAL_DATA_PIN_IN}),
        .q_out(pins_sync)
    );
    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    // Bus events seen on the filtered levels
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
    assign stop_det = scl_s & scl_d_reg & sda_s & ~sda_d_reg;

    assign twi_on = ~SERIAL_PERIPHERAL_ENABLE;
    // Slave logic runs only when selected, in slave mode, and not held in reset
    assign slave_run = twi_on & ~msel_reg & ~srst_reg;
    assign acc_data = (SFR_WR | SFR_RD) & (SFR_ADDR == `TWI_DATA_ADDR);
    assign wr_ctrl = SFR_WR & (SFR_ADDR == `TWI_CONTROL_ADDR);

    // Received bytes queue here so a slow reader stalls the bus, not loses data
    assign buf_in_valid = buf_push;
    assign buf_out_ready = ~done_reg;
    twi_buf #(
        .WIDTH(8),
        .DEPTH(BUF_DEPTH),
        .AW(BUF_AW)
    ) u_buf (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .ce(CE),
        .clr(~slave_run),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(sh_reg),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // A transmitted byte completes when the master clocks its acknowledge bit
    assign tx_byte_done = slave_run & (state_reg == ST_TXACK) & scl_rise;

    // Push decision: at end of a received byte, or when a stretched hold finds room
    always @* begin
        buf_push = 1'b0;
        if (slave_run && buf_in_ready) begin
            if (state_reg == ST_RX && scl_fall && cnt_reg == `TWI_BYTE_BITS) begin
                buf_push = 1'b1;
            end else if (state_reg == ST_HOLD) begin
                buf_push = 1'b1;
            end
        end
    end

    // Edge history of the filtered pin levels
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else if (CE) begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Software registers: control, own address, transmit byte
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            mdo_reg <= 1'b0;
            mde_reg <= 1'b0;
            mco_reg <= 1'b0;
            msel_reg <= 1'b0;
            srst_reg <= 1'b0;
            own_addr_reg <= `TWI_OWN_ADDR_RST;
            tx_data_reg <= `TWI_DATA_RST;
        end else if (CE) begin
            if (wr_ctrl) begin
                mdo_reg <= SFR_WDATA[`TWI_MDO_BIT];
                mde_reg <= SFR_WDATA[`TWI_MDE_BIT];
                mco_reg <= SFR_WDATA[`TWI_MCO_BIT];
                msel_reg <= SFR_WDATA[`TWI_MSEL_BIT];
                srst_reg <= SFR_WDATA[`TWI_SRST_BIT];
            end
            if (SFR_WR && SFR_ADDR == `TWI_OWN_ADDR_ADDR) begin
                own_addr_reg <= SFR_WDATA;
            end
            if (SFR_WR && SFR_ADDR == `TWI_DATA_ADDR) begin
                tx_data_reg <= SFR_WDATA;
            end
        end
    end

    // Master data-in sampled on each clock rising edge while the pin is an input
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            mdi_reg <= 1'b0;
        end else if (CE) begin
            if (twi_on && msel_reg && !mde_reg && scl_rise) begin
                mdi_reg <= sda_s;
            end
        end
    end

    // Byte-done flag and received byte; a new event beats a same-cycle clear
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            done_reg <= 1'b0;
            rx_data_reg <= `TWI_DATA_RST;
        end else if (CE) begin
            if (buf_out_valid && buf_out_ready) begin
                rx_data_reg <= buf_out_data;
                done_reg <= 1'b1;
            end else if (tx_byte_done) begin
                done_reg <= 1'b1;
            end else if (acc_data) begin
                done_reg <= 1'b0;
            end else if (wr_ctrl && !SFR_WDATA[`TWI_DONE_BIT]) begin
                done_reg <= 1'b0;
            end
        end
    end

    // Slave engine; the master outside makes every start, clock and stop
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else if (CE) begin
            if (!slave_run) begin
                state_reg <= ST_IDLE;
                sda_low_reg <= 1'b0;
                scl_low_reg <= 1'b0;
                dir_reg <= 1'b0;
            end else if (start_det) begin
                state_reg <= ST_ADDR;
                cnt_reg <= 4'h0;
                sda_low_reg <= 1'b0;
                scl_low_reg <= 1'b0;
                dir_reg <= 1'b0;
            end else if (stop_det) begin
                state_reg <= ST_IDLE;
                sda_low_reg <= 1'b0;
                scl_low_reg <= 1'b0;
                dir_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_RX: begin
                        if (scl_rise && cnt_reg != `TWI_BYTE_BITS) begin
                            sh_reg <= {sh_reg[6:0], sda_s};
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall && cnt_reg == `TWI_BYTE_BITS) begin
                            if (state_reg == ST_ADDR) begin
                                if (sh_reg[7:1] == own_addr_reg[6:0]) begin
                                    sda_low_reg <= 1'b1;
                                    dir_reg <= sh_reg[0];
                                    state_reg <= ST_ACK;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else if (buf_in_ready) begin
                                sda_low_reg <= 1'b1;
                                state_reg <= ST_ACK;
                            end else begin
                                // No room: stretch the clock until the reader catches up
                                scl_low_reg <= 1'b1;
                                state_reg <= ST_HOLD;
                            end
                        end
                    end
                    ST_HOLD: begin
                        // Acknowledge first; the clock is let go a cycle later so data is set up
                        if (buf_in_ready) begin
                            sda_low_reg <= 1'b1;
                            state_reg <= ST_ACK;
                        end
                    end
                    ST_ACK: begin
                        scl_low_reg <= 1'b0;
                        if (scl_fall) begin
                            cnt_reg <= 4'h0;
                            if (dir_reg) begin
                                // First bit goes out on the fall that ends the acknowledge
                                sh_reg <= {tx_data_reg[6:0], 1'b0};
                                sda_low_reg <= ~tx_data_reg[7];
                                state_reg <= ST_TX;
                            end else begin
                                sda_low_reg <= 1'b0;
                                state_reg <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_reg == `TWI_BYTE_BITS) begin
                                sda_low_reg <= 1'b0;
                                state_reg <= ST_TXACK;
                            end else begin
                                sda_low_reg <= ~sh_reg[7];
                                sh_reg <= {sh_reg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            // Master acknowledge asks for another byte, a refusal ends it
                            state_reg <= sda_s ? ST_IDLE : ST_ACK;
                        end
                    end
                    default: begin
                        sda_low_reg <= 1'b0;
                        scl_low_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Pin drivers: SPI, software master, or open-drain slave, one at a time
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            SERIAL_DATA_PIN_OUT <= 1'b0;
            SERIAL_DATA_PIN_OE <= 1'b0;
            SERIAL_CLOCK_PIN_OUT <= 1'b0;
            SERIAL_CLOCK_PIN_OE <= 1'b0;
            BYTE_DONE_IRQ <= 1'b0;
        end else if (CE) begin
            BYTE_DONE_IRQ <= done_reg;
            if (!twi_on) begin
                SERIAL_DATA_PIN_OUT <= SPI_DATA_OUT;
                SERIAL_DATA_PIN_OE <= SPI_DATA_OE;
                SERIAL_CLOCK_PIN_OUT <= SPI_CLOCK_OUT;
                SERIAL_CLOCK_PIN_OE <= SPI_CLOCK_OE;
            end else if (msel_reg) begin
                SERIAL_DATA_PIN_OUT <= mdo_reg;
                SERIAL_DATA_PIN_OE <= mde_reg;
                SERIAL_CLOCK_PIN_OUT <= mco_reg;
                SERIAL_CLOCK_PIN_OE <= 1'b1;
            end else begin
                SERIAL_DATA_PIN_OUT <= 1'b0;
                SERIAL_DATA_PIN_OE <= sda_low_reg;
                SERIAL_CLOCK_PIN_OUT <= 1'b0;
                SERIAL_CLOCK_PIN_OE <= scl_low_reg;
            end
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads give zero
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            SFR_RDATA <= 8'h00;
        end else if (CE) begin
            if (SFR_RD) begin
                case (SFR_ADDR)
                    `TWI_DATA_ADDR: SFR_RDATA <= rx_data_reg;
                    `TWI_OWN_ADDR_ADDR: SFR_RDATA <= own_addr_reg;
                    `TWI_CONTROL_ADDR: SFR_RDATA <= {mdo_reg, mde_reg, mco_reg, mdi_reg,
                        msel_reg, srst_reg, dir_reg, done_reg};
                    default: SFR_RDATA <= 8'h00;
                endcase
            end
        end
    end
endmodule // twi_top

// *** verilog/twi_regs.vh ***
// Register offsets, field positions and reset values of the two-wire block
`ifndef TWI_REGS_VH
`define TWI_REGS_VH

// Register offsets on the special function register bus
`define TWI_DATA_ADDR 8'h9A
`define TWI_OWN_ADDR_ADDR 8'h9B
`define TWI_CONTROL_ADDR 8'hE8

// Reset values
`define TWI_DATA_RST 8'h00
`define TWI_OWN_ADDR_RST 8'h55
`define TWI_CONTROL_RST 8'h00

// Control register field positions
`define TWI_MDO_BIT 7
`define TWI_MDE_BIT 6
`define TWI_MCO_BIT 5
`define TWI_MDI_BIT 4
`define TWI_MSEL_BIT 3
`define TWI_SRST_BIT 2
`define TWI_DIR_BIT 1
`define TWI_DONE_BIT 0

// Bit count of one byte on the bus
`define TWI_BYTE_BITS 4'h8

`endif

// *** verilog/twi_sync.v ***
// Three-stage synchroniser with agreement filter, one instance per bit
`timescale 1ns/10ps
module twi_sync #(
    parameter WIDTH = 2,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire clk, // System clock
    input wire rst_n, // Synchronous reset, active low
    input wire ce, // Clock enable
    input wire [WIDTH-1:0] d_in, // Asynchronous inputs
    output wire [WIDTH-1:0] q_out // Filtered levels
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg lvl_reg;
            // The first stage feeds only the second; the level moves once stages two and three agree
            always @(posedge clk) begin
                if (!rst_n) begin
                    s1_reg <= INIT[i];
                    s2_reg <= INIT[i];
                    s3_reg <= INIT[i];
                    lvl_reg <= INIT[i];
                end else if (ce) begin
                    s1_reg <= d_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign q_out[i] = lvl_reg;
        end
    endgenerate
endmodule // twi_sync

// *** verilog/twi_buf.v ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module twi_buf #(
    parameter WIDTH = 8,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire clk, // System clock
    input wire rst_n, // Synchronous reset, active low
    input wire ce, // Clock enable
    input wire clr, // Flush all entries
    input wire in_valid, // Write side offers a word
    output wire in_ready, // Buffer has room
    input wire [WIDTH-1:0] in_data, // Word written
    output wire out_valid, // Buffer holds a word
    input wire out_ready, // Read side takes the word
    output wire [WIDTH-1:0] out_data // Oldest word
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    // Full and empty come from the count so both sides see honest flow control
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage is written only at the write pointer, no reset needed
    always @(posedge clk) begin
        if (ce && push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth; depth is a power of two
    always @(posedge clk) begin
        if (!rst_n || (ce && clr)) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // twi_buf

// *** bench/twi_asserts.sv ***
// Port-level checker of the two-wire block
`timescale 1ns/10ps
module twi_asserts (
    input wire SYS_CLK, // Core clock
    input wire RSTN, // Reset, active low
    input wire CE, // Clock enable
    input wire [7:0] SFR_ADDR, // Register address
    input wire SFR_WR, // Write strobe
    input wire SFR_RD, // Read strobe
    input wire [7:0] SFR_WDATA, // Write data
    input wire [7:0] SFR_RDATA, // Read data
    input wire SERIAL_PERIPHERAL_ENABLE, // SPI owns pins
    input wire SPI_DATA_OUT, // SPI data drive
    input wire SPI_DATA_OE, // SPI data enable
    input wire SPI_CLOCK_OUT, // SPI clock drive
    input wire SPI_CLOCK_OE, // SPI clock enable
    input wire SERIAL_DATA_PIN_OUT, // Data drive
    input wire SERIAL_DATA_PIN_OE, // Data enable
    input wire SERIAL_CLOCK_PIN_OUT, // Clock drive
    input wire SERIAL_CLOCK_PIN_OE, // Clock enable
    input wire BYTE_DONE_IRQ // Byte-done flag
);
reg [7:0] ctl_reg, own_reg;
reg [1:0] calm_reg;
wire ctl_wr = CE && SFR_WR && SFR_ADDR == 8'hE8;
// Shadow of writable bits; calm counts settled cycles since mode could change
always @(posedge SYS_CLK) begin
    if (!RSTN) begin
        ctl_reg <= 8'h00;
        own_reg <= 8'h55;
        calm_reg <= 2'h0;
    end else begin
        if (ctl_wr) ctl_reg <= SFR_WDATA;
        if (CE && SFR_WR && SFR_ADDR == 8'h9B) own_reg <= SFR_WDATA;
        if (ctl_wr || SERIAL_PERIPHERAL_ENABLE || !CE) calm_reg <= 2'h0;
        else if (calm_reg != 2'h3) calm_reg <= calm_reg + 2'h1;
    end
end
wire mst = calm_reg[1] && ctl_reg[3];
wire slv = calm_reg[1] && !ctl_reg[3];
default clocking cb @(posedge SYS_CLK); endclocking
default disable iff (!RSTN);
sequence s_rd(a);
    SFR_RD && CE && SFR_ADDR == a;
endsequence
AST_SPI_MUX: assert property ($past(SERIAL_PERIPHERAL_ENABLE) && $past(CE) |->
    SERIAL_DATA_PIN_OE == $past(SPI_DATA_OE) && SERIAL_DATA_PIN_OUT == $past(SPI_DATA_OUT) &&
    SERIAL_CLOCK_PIN_OE == $past(SPI_CLOCK_OE) && SERIAL_CLOCK_PIN_OUT == $past(SPI_CLOCK_OUT))
    else $error("pins do not follow the SPI drive");
AST_MST_CLOCK: assert property (mst |-> SERIAL_CLOCK_PIN_OE &&
    SERIAL_CLOCK_PIN_OUT == ctl_reg[5]) else $error("master clock pin wrong");
AST_MST_DATA: assert property (mst |-> SERIAL_DATA_PIN_OE == ctl_reg[6] &&
    (!ctl_reg[6] || SERIAL_DATA_PIN_OUT == ctl_reg[7])) else $error("master data pin wrong");
AST_SLV_RESET: assert property (slv && ctl_reg[2] |->
    !SERIAL_DATA_PIN_OE && !SERIAL_CLOCK_PIN_OE) else $error("slave in reset drives a pin");
AST_SLV_OPEN_DRAIN: assert property (slv |->
    !SERIAL_DATA_PIN_OUT && !SERIAL_CLOCK_PIN_OUT) else $error("slave drives a pin high");
AST_RDATA_HOLD: assert property (!($past(SFR_RD) && $past(CE)) |->
    $stable(SFR_RDATA)) else $error("read data moved without a read");
AST_OWN_ADDR: assert property (s_rd(8'h9B) |=> SFR_RDATA == own_reg)
    else $error("own address read wrong");
AST_IRQ_MIRROR: assert property (s_rd(8'hE8) |=> SFR_RDATA[0] == BYTE_DONE_IRQ)
    else $error("flag and irq disagree");
AST_CTL_READ: assert property (s_rd(8'hE8) |=> SFR_RDATA[7:5] == ctl_reg[7:5] &&
    SFR_RDATA[3:2] == ctl_reg[3:2]) else $error("control read wrong");
AST_UNMAPPED: assert property (SFR_RD && CE && SFR_ADDR != 8'h9A && SFR_ADDR != 8'h9B &&
    SFR_ADDR != 8'hE8 |=> SFR_RDATA == 8'h00) else $error("unmapped read not zero");
COV_DATA_RD: cover property (s_rd(8'h9A));
endmodule // twi_asserts

// *** bench/twi_partner.sv ***
// External bus master model driving the shared pins
`timescale 1ns/10ps
module twi_partner (
    input wire clk, // Core clock
    input wire sda_w, // Data wire level
    input wire scl_w, // Clock wire level
    output reg m_sda, // Data drive, 1 releases
    output reg m_scl // Clock drive, 1 releases
);
initial begin
    m_sda = 1'b1;
    m_scl = 1'b1;
end
// Long phases leave room for the pin synchronisers
task half;
    repeat (12) @(posedge clk);
endtask
// Release clock and wait while the slave stretches it
task rise;
    integer n;
    m_scl <= 1'b1;
    n = 0;
    @(posedge clk);
    while (scl_w !== 1'b1 && n < 20000) begin
        @(posedge clk);
        n = n + 1;
    end
    half;
endtask
task fall;
    m_scl <= 1'b0;
    half;
endtask
task start;
    m_sda <= 1'b1;
    rise;
    m_sda <= 1'b0;
    half;
    fall;
endtask
task stop;
    m_sda <= 1'b0;
    half;
    rise;
    m_sda <= 1'b1;
    half;
endtask
// One clock: data set in the low phase, wire sampled late in the high phase
task bitx(input b, output s);
    m_sda <= b;
    half;
    rise;
    s = sda_w;
    fall;
endtask
task wbyte(input [7:0] d, output ack);
    integer i;
    reg s;
    for (i = 7; i >= 0; i = i - 1) bitx(d[i], s);
    bitx(1'b1, ack);
endtask
task rbyte(input ack_in, output [7:0] d);
    integer i;
    reg s;
    for (i = 7; i >= 0; i = i - 1) bitx(1'b1, d[i]);
    bitx(ack_in, s);
endtask
endmodule // twi_partner

// *** bench/tb_top.sv ***
// Self-checking bench of the two-wire block
`timescale 1ns/10ps
module tb_top;
reg clk, rstn, ce, wr, rd, serial_peripheral_enable, s_do, s_doe, s_co, s_coe, ack, b;
reg [7:0] addr, wdata, v, c, own;
reg [7:0] buf_q [0:3];
wire [7:0] rdata;
wire d_out, d_oe, c_out, c_oe, irq, m_sda, m_scl;
// Pull-ups on both wires; any low drive wins
wire sda_w = (d_oe ? d_out : 1'b1) & m_sda;
wire scl_w = (c_oe ? c_out : 1'b1) & m_scl;
integer mismatches, checked, i;
twi_top i_dut (.SYS_CLK(clk), .RSTN(rstn), .CE(ce), .SFR_ADDR(addr), .SFR_WR(wr),
    .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SERIAL_PERIPHERAL_ENABLE(serial_peripheral_enable),
    .SPI_DATA_OUT(s_do), .SPI_DATA_OE(s_doe), .SPI_CLOCK_OUT(s_co), .SPI_CLOCK_OE(s_coe),
    .SERIAL_DATA_PIN_IN(sda_w), .SERIAL_DATA_PIN_OUT(d_out), .SERIAL_DATA_PIN_OE(d_oe),
    .SERIAL_CLOCK_PIN_IN(scl_w), .SERIAL_CLOCK_PIN_OUT(c_out), .SERIAL_CLOCK_PIN_OE(c_oe),
    .BYTE_DONE_IRQ(irq));
twi_partner p (.clk(clk), .sda_w(sda_w), .scl_w(scl_w), .m_sda(m_sda), .m_scl(m_scl));
initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
end
function exp_ack(input [7:0] a, input [7:0] o);
    exp_ack = (a[7:1] == o[6:0]) ? 1'b0 : 1'b1;
endfunction
task chk(input [8*12-1:0] name, input [7:0] e, input [7:0] g);
    checked = checked + 1;
    if (e !== g) begin
        mismatches = mismatches + 1;
        $display("wrong value %0s expected %h seen %h", name, e, g);
    end
endtask
task sfr_wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
endtask
// Read data is taken one cycle after the strobe edge
task sfr_rd(input [7:0] a, output [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
endtask
task wait_irq;
    integer n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
        @(posedge clk);
        n = n + 1;
    end
    chk("irq set", 8'h01, {7'h0, irq});
endtask
task wr_xfer(input [7:0] a, input integer n, input e);
    integer k;
    p.start;
    p.wbyte(a, ack);
    chk("addr ack", {7'h0, e}, {7'h0, ack});
    if (!e) sfr_rd(8'hE8, c);
    if (!e) chk("dir rx", 8'h00, {7'h0, c[1]});
    for (k = 0; k < n; k = k + 1) begin
        p.wbyte(buf_q[k], ack);
        chk("data ack", 8'h00, {7'h0, ack});
    end
    p.stop;
endtask
task print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
// Watchdog far beyond the expected run length
initial begin
    #160000;
    mismatches = mismatches + 1;
    print_verdict;
end
initial begin
    {rstn, wr, rd, serial_peripheral_enable, s_do, s_doe, s_co, s_coe} = 8'h00;
    {ce, addr, wdata, mismatches, checked} = 0;
    ce = 1'b1;
    void'($urandom(32'hA6610D36));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    sfr_rd(8'h9A, v);
    chk("data rst", 8'h00, v);
    sfr_rd(8'h9B, v);
    chk("own rst", 8'h55, v);
    sfr_rd(8'hE8, v);
    chk("ctl rst", 8'h00, v);
    sfr_rd(8'h77, v);
    chk("unmapped", 8'h00, v);
    // A write while the block is frozen must be lost
    own = $urandom & 8'h7F;
    sfr_wr(8'h9B, own);
    ce <= 1'b0;
    sfr_wr(8'h9B, ~own);
    ce <= 1'b1;
    sfr_rd(8'h9B, v);
    chk("own addr", own, v);
    for (i = 0; i < 4; i = i + 1) begin
        v = $urandom | 8'h08;
        sfr_wr(8'hE8, v);
        repeat (3) @(posedge clk);
        chk("clk pin", {7'h0, v[5]}, {7'h0, c_out});
        chk("data oe", {7'h0, v[6]}, {7'h0, d_oe});
    end
    // Data-in bit follows the wire on a software clock rise, both levels
    for (i = 0; i < 2; i = i + 1) begin
        b = i[0] ^ own[0];
        p.m_sda <= b;
        sfr_wr(8'hE8, 8'h08);
        repeat (8) @(posedge clk);
        sfr_wr(8'hE8, 8'h28);
        repeat (8) @(posedge clk);
        sfr_rd(8'hE8, v);
        chk("data in", {7'h0, b}, {7'h0, v[4]});
    end
    p.m_sda <= 1'b1;
    serial_peripheral_enable <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
        v = $urandom;
        {s_do, s_doe, s_co, s_coe} <= v[3:0];
        repeat (3) @(posedge clk);
        chk("spi oe", {7'h0, v[2]}, {7'h0, d_oe});
    end
    serial_peripheral_enable <= 1'b0;
    sfr_wr(8'hE8, 8'h00);
    repeat (8) @(posedge clk);
    buf_q[0] = $urandom;
    wr_xfer({own[6:0], 1'b0}, 1, exp_ack({own[6:0], 1'b0}, own));
    wait_irq;
    sfr_rd(8'h9A, v);
    chk("rx byte", buf_q[0], v);
    repeat (3) @(posedge clk);
    chk("irq clr", 8'h00, {7'h0, irq});
    v = {own[6:0] ^ 7'h01, 1'b0};
    wr_xfer(v, 0, exp_ack(v, own));
    sfr_wr(8'hE8, 8'h04);
    repeat (4) @(posedge clk);
    wr_xfer({own[6:0], 1'b0}, 0, 1'b1);
    sfr_wr(8'hE8, 8'h00);
    // Read transfer: slave sends the data register and marks itself transmitter
    v = $urandom;
    sfr_wr(8'h9A, v);
    p.start;
    p.wbyte({own[6:0], 1'b1}, ack);
    chk("rd ack", 8'h00, {7'h0, ack});
    sfr_rd(8'hE8, c);
    chk("dir tx", 8'h01, {7'h0, c[1]});
    p.rbyte(1'b1, c);
    chk("tx byte", v, c);
    wait_irq;
    p.stop;
    sfr_wr(8'h9A, c);
    repeat (3) @(posedge clk);
    chk("irq wr clr", 8'h00, {7'h0, irq});
    // Slow reader: the fourth byte must wait behind a stretched clock
    for (i = 0; i < 4; i = i + 1) buf_q[i] = $urandom;
    fork
        wr_xfer({own[6:0], 1'b0}, 4, 1'b0);
        begin
            repeat (3000) @(posedge clk);
            for (i = 0; i < 4; i = i + 1) begin
                wait_irq;
                sfr_rd(8'h9A, v);
                chk("buffered", buf_q[i], v);
                repeat (4) @(posedge clk);
            end
        end
    join
    print_verdict;
end
endmodule // tb_top
bind twi_top twi_asserts i_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .SFR_ADDR(SFR_ADDR),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .SERIAL_PERIPHERAL_ENABLE(SERIAL_PERIPHERAL_ENABLE), .SPI_DATA_OUT(SPI_DATA_OUT),
    .SPI_DATA_OE(SPI_DATA_OE), .SPI_CLOCK_OUT(SPI_CLOCK_OUT), .SPI_CLOCK_OE(SPI_CLOCK_OE),
    .SERIAL_DATA_PIN_OUT(SERIAL_DATA_PIN_OUT), .SERIAL_DATA_PIN_OE(SERIAL_DATA_PIN_OE),
    .SERIAL_CLOCK_PIN_OUT(SERIAL_CLOCK_PIN_OUT), .SERIAL_CLOCK_PIN_OE(SERIAL_CLOCK_PIN_OE),
    .BYTE_DONE_IRQ(BYTE_DONE_IRQ));
